//--- hdl/srti_defs.svh
`ifndef SRTI_DEFS_SVH
`define SRTI_DEFS_SVH
`define SRTI_ADDR_ALS_HI 8'h85
`define SRTI_ADDR_ALS_LO 8'h86
`define SRTI_ADDR_BIO_HI 8'h87
`define SRTI_ADDR_BIO_LO 8'h88
`define SRTI_ADDR_ICTL 8'h89
`define SRTI_ADDR_LTH_HI 8'h8A
`define SRTI_ADDR_LTH_LO 8'h8B
`define SRTI_ADDR_HTH_HI 8'h8C
`define SRTI_ADDR_HTH_LO 8'h8D
`define SRTI_ADDR_STAT 8'h8E
`define SRTI_ICTL_CNT_MSB 7
`define SRTI_ICTL_CNT_LSB 5
`define SRTI_ICTL_BIO_EN 3
`define SRTI_ICTL_ALS_EN 2
`define SRTI_ICTL_TH_EN 1
`define SRTI_ICTL_SEL 0
`define SRTI_ST_BIO 3
`define SRTI_ST_ALS 2
`define SRTI_ST_LOW 1
`define SRTI_ST_HIGH 0
`define SRTI_ICTL_RESET 8'h00
`define SRTI_WORD_RESET 16'h0000
`endif

//--- hdl/srti_pkg.sv
package srti_pkg;
  typedef logic [15:0] srti_word_t;
  typedef enum logic [1:0] {
    SRTI_INSIDE = 2'b00,
    SRTI_ABOVE = 2'b01,
    SRTI_BELOW = 2'b11
  } srti_zone_t;
endpackage

//--- hdl/srti_hit_counter.sv
`timescale 1ns/10ps
`include "srti_defs.svh"
module srti_hit_counter
  import srti_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_sample,
  input wire srti_word_t i_value,
  input wire srti_word_t i_low,
  input wire srti_word_t i_high,
  input wire logic [2:0] i_count_code,
  output logic o_fire_high,
  output logic o_fire_low
);
  typedef struct packed {
    logic [7:0] hits;
    srti_zone_t zone;
  } srti_hc_state_t;
  srti_hc_state_t st;
  srti_hc_state_t next_st;
  logic [7:0] target;
  srti_zone_t zone_now;
  ////////////////////////////////////////////////////////////
  always_comb begin
    target = 8'h01 << i_count_code;
    if (i_value > i_high) begin
      zone_now = SRTI_ABOVE;
    end else if (i_value < i_low) begin
      zone_now = SRTI_BELOW;
    end else begin
      zone_now = SRTI_INSIDE;
    end
    next_st = st;
    o_fire_high = 1'b0;
    o_fire_low = 1'b0;
    if (i_sample) begin
      next_st.zone = zone_now;
      if (zone_now == SRTI_INSIDE || zone_now != st.zone) begin
        // a change of side restarts the run too
        next_st.hits = (zone_now == SRTI_INSIDE) ? 8'h00 : 8'h01;
      end else if (st.hits != 8'hFF) begin
        next_st.hits = st.hits + 8'h01;
      end
      // fires once, on reaching the count exactly
      if (zone_now != SRTI_INSIDE && next_st.hits == target) begin
        o_fire_high = (zone_now == SRTI_ABOVE);
        o_fire_low = (zone_now == SRTI_BELOW);
      end
    end
  end
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      st <= '{hits: 8'h00, zone: SRTI_INSIDE};
    end else begin
      st <= next_st;
    end
  end
endmodule

//--- hdl/srti_regs.sv
`timescale 1ns/10ps
`include "srti_defs.svh"
module srti_regs
  import srti_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_bio_valid,
  input wire srti_word_t i_bio_data,
  input wire logic i_als_valid,
  input wire srti_word_t i_als_data,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_int_n
);
  typedef struct packed {
    srti_word_t bio;
    srti_word_t als;
    logic [7:0] ictl;
    srti_word_t low_th;
    srti_word_t high_th;
    logic [3:0] status;
    logic [7:0] rdata;
  } srti_state_t;
  srti_state_t st;
  srti_state_t next_st;
  logic sample;
  srti_word_t sample_value;
  logic fire_high;
  logic fire_low;
  logic [3:0] set_bits;
  logic [3:0] clr_bits;
  ////////////////////////////////////////////////////////////
  // compare the new sample itself, not the stale stored word
  assign sample = st.ictl[`SRTI_ICTL_SEL] ? i_als_valid : i_bio_valid;
  assign sample_value = st.ictl[`SRTI_ICTL_SEL] ? i_als_data : i_bio_data;
  srti_hit_counter u_hits (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_sample(sample),
    .i_value(sample_value),
    .i_low(st.low_th),
    .i_high(st.high_th),
    .i_count_code(st.ictl[`SRTI_ICTL_CNT_MSB:`SRTI_ICTL_CNT_LSB]),
    .o_fire_high(fire_high),
    .o_fire_low(fire_low)
  );
  ////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    set_bits = 4'h0;
    clr_bits = 4'h0;
    if (i_bio_valid) begin
      next_st.bio = i_bio_data;
    end
    if (i_als_valid) begin
      next_st.als = i_als_data;
    end
    set_bits[`SRTI_ST_BIO] = i_bio_valid & st.ictl[`SRTI_ICTL_BIO_EN];
    set_bits[`SRTI_ST_ALS] = i_als_valid & st.ictl[`SRTI_ICTL_ALS_EN];
    set_bits[`SRTI_ST_HIGH] = fire_high & st.ictl[`SRTI_ICTL_TH_EN];
    set_bits[`SRTI_ST_LOW] = fire_low & st.ictl[`SRTI_ICTL_TH_EN];
    if (i_wr) begin
      unique case (i_addr)
        `SRTI_ADDR_ICTL: begin
          next_st.ictl = {i_wdata[7:5], 1'b0, i_wdata[3:0]};
        end
        `SRTI_ADDR_LTH_HI: next_st.low_th[15:8] = i_wdata;
        `SRTI_ADDR_LTH_LO: next_st.low_th[7:0] = i_wdata;
        `SRTI_ADDR_HTH_HI: next_st.high_th[15:8] = i_wdata;
        `SRTI_ADDR_HTH_LO: next_st.high_th[7:0] = i_wdata;
        `SRTI_ADDR_STAT: clr_bits = i_wdata[3:0];
        // result bytes and unmapped addresses drop writes
        default: begin
        end
      endcase
    end
    // set wins over a clear in the same cycle
    next_st.status = (st.status & ~clr_bits) | set_bits;
    if (i_rd) begin
      unique case (i_addr)
        `SRTI_ADDR_ALS_HI: next_st.rdata = st.als[15:8];
        `SRTI_ADDR_ALS_LO: next_st.rdata = st.als[7:0];
        `SRTI_ADDR_BIO_HI: next_st.rdata = st.bio[15:8];
        `SRTI_ADDR_BIO_LO: next_st.rdata = st.bio[7:0];
        `SRTI_ADDR_ICTL: next_st.rdata = st.ictl;
        `SRTI_ADDR_LTH_HI: next_st.rdata = st.low_th[15:8];
        `SRTI_ADDR_LTH_LO: next_st.rdata = st.low_th[7:0];
        `SRTI_ADDR_HTH_HI: next_st.rdata = st.high_th[15:8];
        `SRTI_ADDR_HTH_LO: next_st.rdata = st.high_th[7:0];
        `SRTI_ADDR_STAT: next_st.rdata = {4'h0, st.status};
        default: next_st.rdata = 8'h00;
      endcase
    end
  end
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      st <= '{bio: `SRTI_WORD_RESET, als: `SRTI_WORD_RESET, ictl: `SRTI_ICTL_RESET,
              low_th: `SRTI_WORD_RESET, high_th: `SRTI_WORD_RESET, status: 4'h0,
              rdata: 8'h00};
    end else begin
      st <= next_st;
    end
  end
  assign o_rdata = st.rdata;
  assign o_int_n = ~(|st.status);
endmodule

//--- verif/srti_regs_checker.sv
`timescale 1ns/10ps
module srti_regs_checker
  import srti_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_bio_valid,
  input wire logic i_als_valid,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic o_int_n,
  input wire srti_word_t i_bio_data,
  input wire srti_word_t i_als_data,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // mirrors of device state, so reads are judged without peeking inside
  logic [7:0] ictl, bio_hi, als_hi;
  wire ictl_wr = i_wr && i_addr == 8'h89;
  always_ff @(posedge i_mclk) begin
    ictl <= i_rst ? 8'h00 : ictl_wr ? i_wdata : ictl;
    bio_hi <= i_rst ? 8'h00 : i_bio_valid ? i_bio_data[15:8] : bio_hi;
    als_hi <= i_rst ? 8'h00 : i_als_valid ? i_als_data[15:8] : als_hi;
  end
  a_bio_hi: assert property (i_rd && i_addr == 8'h87 |=> o_rdata == $past(bio_hi))
    else $error("bio hi");
  a_als_hi: assert property (i_rd && i_addr == 8'h85 |=> o_rdata == $past(als_hi))
    else $error("als hi");
  a_low_thr: assert property (i_wr && i_addr == 8'h8B ##2 i_rd && i_addr == 8'h8B
    |=> o_rdata == $past(i_wdata, 3)) else $error("low thr");
  a_high_thr: assert property (i_wr && i_addr == 8'h8D ##2 i_rd && i_addr == 8'h8D
    |=> o_rdata == $past(i_wdata, 3)) else $error("high thr");
  a_bio_irq: assert property (i_bio_valid && ictl[3] |=> !o_int_n) else $error("bio");
  a_als_irq: assert property (i_als_valid && ictl[2] |=> !o_int_n) else $error("als");
  a_flag_hold: assert property (!o_int_n && !(i_wr && i_addr == 8'h8E) |=> !o_int_n)
    else $error("flag hold");
  a_src_sel: assert property (o_int_n && ictl[3:0] == 4'h2 && !i_bio_valid && !ictl_wr
    |=> o_int_n) else $error("src sel");
  c_clear: cover property (!o_int_n ##1 o_int_n);
  c_als_all: cover property (i_als_valid && ictl[2:0] == 3'h7);
  c_bio_lo: cover property (i_rd && i_addr == 8'h88);
endmodule

//--- verif/srti_host.sv
`timescale 1ns/10ps
module srti_host (
  input wire logic i_mclk,
  input wire logic [7:0] i_rdata,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata
);
  initial {o_wr, o_rd, o_addr, o_wdata} = 18'h00000;
  // released bus shows the inverse, so a stale value never passes
  task automatic wr(input logic [7:0] a, d);
    @(negedge i_mclk);
    {o_wr, o_addr, o_wdata} = {1'b1, a, d};
    @(negedge i_mclk);
    {o_wr, o_addr, o_wdata} = {1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(negedge i_mclk);
    {o_rd, o_addr} = {1'b1, a};
    @(negedge i_mclk);
    q = i_rdata;
    {o_rd, o_addr} = {1'b0, ~a};
  endtask
endmodule

//--- verif/test_sensor_result_threshold_irq.sv
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module test_sensor_result_threshold_irq;
  logic i_mclk, i_rst, bv, av, wr, rd, int_n;
  logic [15:0] bd, ad;
  logic [7:0] addr, wd, rdata, q;
  int err_count = 0, n_checks = 0;
  srti_regs dut_u (.i_mclk(i_mclk), .i_rst(i_rst), .i_bio_valid(bv), .i_bio_data(bd),
    .i_als_valid(av), .i_als_data(ad), .i_wr(wr), .i_rd(rd), .i_addr(addr),
    .i_wdata(wd), .o_rdata(rdata), .o_int_n(int_n));
  srti_host h (.i_mclk(i_mclk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd), .o_addr(addr),
    .o_wdata(wd));
  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end
  task close_out;
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task meas(input logic s, input logic [15:0] v);
    @(negedge i_mclk);
    if (s) {av, ad} = {1'b1, v};
    else {bv, bd} = {1'b1, v};
    @(negedge i_mclk);
    {bv, av, bd, ad} = {2'b00, ~bd, ~ad};
  endtask
  task t_result;
    h.rd(8'h89, q);
    `CHK(q, 8'h00)
    meas(0, 16'hA55A);
    meas(1, 16'h3CC3);
    h.wr(8'h87, 8'hFF);
    h.wr(8'h88, 8'h00);
    h.rd(8'h87, q);
    `CHK(q, 8'hA5)
    h.rd(8'h88, q);
    `CHK(q, 8'h5A)
    h.rd(8'h85, q);
    `CHK(q, 8'h3C)
    `CHK(int_n, 1'b1)
  endtask
  // window 0180h..1040h; the loop walks every hit-count code
  task t_count;
    h.wr(8'h8A, 8'h01);
    h.wr(8'h8C, 8'h10);
    h.wr(8'h8B, 8'h80);
    h.rd(8'h8B, q);
    `CHK(q, 8'h80)
    h.wr(8'h8D, 8'h40);
    h.rd(8'h8D, q);
    `CHK(q, 8'h40)
    for (int c = 0; c < 8; c++) begin
      h.wr(8'h89, {c[2:0], 5'h02});
      // ambient beyond window, ignored while biosensor is chosen
      meas(1, 16'h2000);
      `CHK(int_n, 1'b1)
      meas(0, 16'h0800);
      repeat ((1 << c) - 1) meas(0, 16'h2000);
      `CHK(int_n, 1'b1)
      meas(0, 16'h2000);
      `CHK(int_n, 1'b0)
      h.wr(8'h8E, 8'h01);
      `CHK(int_n, 1'b1)
    end
  endtask
  task t_ready;
    // back inside first, so a stray biosensor hit would fire at once
    meas(0, 16'h0800);
    h.wr(8'h89, 8'h1F);
    h.rd(8'h89, q);
    `CHK(q, 8'h0F)
    meas(0, 16'h2000);
    h.rd(8'h8E, q);
    `CHK(q, 8'h08)
    meas(1, 16'h0100);
    h.rd(8'h8E, q);
    `CHK(q, 8'h0E)
    h.wr(8'h8E, 8'h0F);
    `CHK(int_n, 1'b1)
  endtask
  initial begin
    {i_rst, bv, av, bd, ad} = {3'h4, 32'h00000000};
    repeat (16) @(posedge i_mclk);
    @(negedge i_mclk);
    i_rst = 1'b0;
    t_result;
    t_count;
    t_ready;
    close_out;
  end
  initial begin
    #100000;
    err_count++;
    close_out;
  end
endmodule
bind srti_regs srti_regs_checker chk_u (.*);
